// File: design/adc_offset_gain_correction.sv
// register file, k selection and diagnostic source control around two correction paths
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
module adc_offset_gain_correction #(
  parameter int FW = 24,
  parameter logic [15:0] FACTORY_GAIN = aogc_pkg::AOGC_GAIN_NOM
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [aogc_pkg::AOGC_AW-1:0] addr_i,
  input wire logic [aogc_pkg::AOGC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [aogc_pkg::AOGC_DW-1:0] rdata_o,
  // filter samples
  input wire logic signed [FW-1:0] cur_sample_i,
  input wire logic cur_valid_i,
  input wire logic signed [FW-1:0] aux_sample_i,
  input wire logic aux_valid_i,
  // converter state and calibration writes
  input wire logic adc_idle_i,
  input wire logic cal_wr_i,
  input wire logic [1:0] cal_sel_i,
  input wire logic [15:0] cal_coeff_i,
  // result strobes
  output logic cur_ready_o,
  output logic aux_ready_o,
  // diagnostic current sources
  output logic shunt_pos_src_en_o,
  output logic shunt_neg_src_en_o,
  output logic temp_src_en_o,
  output logic switched_ground_src_en_o,
  output logic atten_src_en_o
);
  import aogc_pkg::*;

  // refused at elaboration: the correction headroom only covers these widths
  if (FW < 16 || FW > 32) begin : fw_range_chk
    $error("adc_offset_gain_correction: filter width must be 16 to 32");
  end

  // k as a shift from gain code, mode and reference choice
  function automatic logic [2:0] k_shift(input logic [3:0] gcode, input logic [1:0] mbits, input logic half);
    logic [2:0] k;
    aogc_mode_t m;
    m = aogc_mode_t'(mbits);
    k = AOGC_K1;
    if (gcode == AOGC_G2 || gcode == AOGC_G128) begin
      k = AOGC_K2;
    end else if (gcode == AOGC_G256) begin
      k = AOGC_K4;
    end else if (gcode == AOGC_G512) begin
      k = AOGC_K8;
    end
    case (m)
      AOGC_LOW_POWER: begin
        if (gcode == AOGC_G128) begin
          k = AOGC_K32;
        end
        if (half) begin
          k = k + 3'h1;
        end
      end
      AOGC_LOW_POWER_PLUS: begin
        if (gcode == AOGC_G512) begin
          k = AOGC_K8;
        end
        if (half) begin
          k = k + 3'h1;
        end
      end
      default: begin
        k = k;
      end
    endcase
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] cur_off_r, cur_off_nxt;
  logic [15:0] cur_gain_r, cur_gain_nxt;
  logic [15:0] aux_off_r, aux_off_nxt;
  logic [15:0] aux_gain_r, aux_gain_nxt;
  logic [15:0] cur_ctrl_r, cur_ctrl_nxt;
  logic [15:0] aux_ctrl_r, aux_ctrl_nxt;
  logic [15:0] hv_cfg_r, hv_cfg_nxt;
  logic [4:0] mode_r, mode_nxt;
  logic [15:0] cur_res_r, cur_res_nxt;
  logic [15:0] aux_res_r, aux_res_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic cur_ready_r, aux_ready_r;
  logic [4:0] diag_r, diag_nxt;

  aogc_corr_if #(.FW(FW)) cur_if ();
  aogc_corr_if #(.FW(FW)) aux_if ();

  logic wr_cur_off, wr_cur_gain, wr_aux_off, wr_aux_gain;
  logic wr_stat, rd_cur_res, rd_aux_res;

  // address decode
  always_comb begin
    wr_cur_off = 1'b0;
    wr_cur_gain = 1'b0;
    wr_aux_off = 1'b0;
    wr_aux_gain = 1'b0;
    wr_stat = 1'b0;
    if (!wr_i) begin
      wr_stat = 1'b0;
    end else if (addr_i == AOGC_CUR_OFF_A) begin
      wr_cur_off = adc_idle_i;
    end else if (addr_i == AOGC_CUR_GAIN_A) begin
      wr_cur_gain = adc_idle_i;
    end else if (addr_i == AOGC_AUX_OFF_A) begin
      wr_aux_off = adc_idle_i;
    end else if (addr_i == AOGC_AUX_GAIN_A) begin
      wr_aux_gain = adc_idle_i;
    end else if (addr_i == AOGC_STAT_A) begin
      wr_stat = 1'b1;
    end
    rd_cur_res = rd_i && addr_i == AOGC_CUR_RES_A;
    rd_aux_res = rd_i && addr_i == AOGC_AUX_RES_A;
  end

  // coefficients and control; calibration beats a software write in the same cycle
  always_comb begin
    cur_off_nxt = cur_off_r;
    cur_gain_nxt = cur_gain_r;
    aux_off_nxt = aux_off_r;
    aux_gain_nxt = aux_gain_r;
    cur_ctrl_nxt = cur_ctrl_r;
    aux_ctrl_nxt = aux_ctrl_r;
    hv_cfg_nxt = hv_cfg_r;
    mode_nxt = mode_r;
    if (wr_cur_off) begin
      cur_off_nxt = wdata_i;
    end
    if (wr_cur_gain) begin
      cur_gain_nxt = wdata_i;
    end
    if (wr_aux_off) begin
      aux_off_nxt = wdata_i;
    end
    if (wr_aux_gain) begin
      aux_gain_nxt = wdata_i;
    end
    if (cal_wr_i) begin
      case (cal_sel_i)
        AOGC_CAL_CUR_OFF: cur_off_nxt = cal_coeff_i;
        AOGC_CAL_CUR_GAIN: cur_gain_nxt = cal_coeff_i;
        AOGC_CAL_AUX_OFF: aux_off_nxt = cal_coeff_i;
        default: aux_gain_nxt = cal_coeff_i;
      endcase
    end
    if (wr_i && addr_i == AOGC_CUR_CTRL_A) begin
      cur_ctrl_nxt = wdata_i;
    end
    if (wr_i && addr_i == AOGC_AUX_CTRL_A) begin
      aux_ctrl_nxt = wdata_i;
    end
    if (wr_i && addr_i == AOGC_HV_CFG_A) begin
      hv_cfg_nxt = wdata_i;
    end
    if (wr_i && addr_i == AOGC_MODE_A) begin
      mode_nxt = wdata_i[4:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_off_r <= AOGC_OFF_RST;
      cur_gain_r <= FACTORY_GAIN;
      aux_off_r <= AOGC_OFF_RST;
      aux_gain_r <= AOGC_GAIN_NOM;
      cur_ctrl_r <= AOGC_CTRL_RST;
      aux_ctrl_r <= AOGC_CTRL_RST;
      hv_cfg_r <= AOGC_CTRL_RST;
      mode_r <= 5'h00;
    end else begin
      cur_off_r <= cur_off_nxt;
      cur_gain_r <= cur_gain_nxt;
      aux_off_r <= aux_off_nxt;
      aux_gain_r <= aux_gain_nxt;
      cur_ctrl_r <= cur_ctrl_nxt;
      aux_ctrl_r <= aux_ctrl_nxt;
      hv_cfg_r <= hv_cfg_nxt;
      mode_r <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // correction paths

  assign cur_if.sample = cur_sample_i;
  assign cur_if.valid = cur_valid_i;
  assign cur_if.offset = cur_off_r;
  assign cur_if.gain = cur_gain_r;
  assign cur_if.kshift = k_shift(cur_ctrl_r[AOGC_GCODE_LSB +: 4], mode_r[AOGC_MODE_LSB +: 2],
                                 mode_r[AOGC_HALFREF_BIT]);
  assign cur_if.unipolar = mode_r[AOGC_CUR_UNI_BIT];
  assign aux_if.sample = aux_sample_i;
  assign aux_if.valid = aux_valid_i;
  assign aux_if.offset = aux_off_r;
  assign aux_if.gain = aux_gain_r;
  assign aux_if.kshift = AOGC_K1;
  assign aux_if.unipolar = mode_r[AOGC_AUX_UNI_BIT];

  aogc_corr #(.FW(FW)) u_cur (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cif(cur_if)
  );

  aogc_corr #(.FW(FW)) u_aux (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cif(aux_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // results and sticky status; a setting event wins over a clear in the same cycle

  always_comb begin
    logic [7:0] setb;
    logic [7:0] clrb;
    setb = 8'h00;
    clrb = 8'h00;
    cur_res_nxt = cur_res_r;
    aux_res_nxt = aux_res_r;
    if (cur_if.done) begin
      cur_res_nxt = cur_if.result;
    end
    if (aux_if.done) begin
      aux_res_nxt = aux_if.result;
    end
    setb[AOGC_ST_CUR_OVF] = cur_if.ovf;
    setb[AOGC_ST_CUR_UNF] = cur_if.unf;
    setb[AOGC_ST_AUX_OVF] = aux_if.ovf;
    setb[AOGC_ST_AUX_UNF] = aux_if.unf;
    setb[AOGC_ST_CUR_NEW] = cur_if.done;
    setb[AOGC_ST_AUX_NEW] = aux_if.done;
    // a result replaced before software read it
    setb[AOGC_ST_CUR_LOST] = cur_if.done && stat_r[AOGC_ST_CUR_NEW] && !rd_cur_res;
    setb[AOGC_ST_AUX_LOST] = aux_if.done && stat_r[AOGC_ST_AUX_NEW] && !rd_aux_res;
    if (wr_stat) begin
      clrb = wdata_i[7:0] & AOGC_W1C_MASK[7:0];
    end
    clrb[AOGC_ST_CUR_NEW] = rd_cur_res;
    clrb[AOGC_ST_AUX_NEW] = rd_aux_res;
    stat_nxt = (stat_r & ~clrb) | setb;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_res_r <= 16'h0000;
      aux_res_r <= 16'h0000;
      stat_r <= 8'h00;
      cur_ready_r <= 1'b0;
      aux_ready_r <= 1'b0;
    end else begin
      cur_res_r <= cur_res_nxt;
      aux_res_r <= aux_res_nxt;
      stat_r <= stat_nxt;
      cur_ready_r <= cur_if.done;
      aux_ready_r <= aux_if.done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data only in the cycle after the strobe, zero otherwise

  always_comb begin
    rdata_nxt = 16'h0000;
    if (!rd_i) begin
      rdata_nxt = 16'h0000;
    end else if (addr_i == AOGC_CUR_OFF_A) begin
      rdata_nxt = cur_off_r;
    end else if (addr_i == AOGC_CUR_GAIN_A) begin
      rdata_nxt = cur_gain_r;
    end else if (addr_i == AOGC_AUX_OFF_A) begin
      rdata_nxt = aux_off_r;
    end else if (addr_i == AOGC_AUX_GAIN_A) begin
      rdata_nxt = aux_gain_r;
    end else if (addr_i == AOGC_CUR_CTRL_A) begin
      rdata_nxt = cur_ctrl_r;
    end else if (addr_i == AOGC_AUX_CTRL_A) begin
      rdata_nxt = aux_ctrl_r;
    end else if (addr_i == AOGC_HV_CFG_A) begin
      rdata_nxt = hv_cfg_r;
    end else if (addr_i == AOGC_MODE_A) begin
      rdata_nxt = {11'h000, mode_r};
    end else if (addr_i == AOGC_CUR_RES_A) begin
      rdata_nxt = cur_res_r;
    end else if (addr_i == AOGC_AUX_RES_A) begin
      rdata_nxt = aux_res_r;
    end else if (addr_i == AOGC_STAT_A) begin
      rdata_nxt = {7'h00, adc_idle_i, stat_r};
    end
  end

  // diagnostic sources follow the control bits one cycle later
  always_comb begin
    diag_nxt[0] = cur_ctrl_r[AOGC_DIAG_POS_BIT];
    diag_nxt[1] = cur_ctrl_r[AOGC_DIAG_NEG_BIT];
    diag_nxt[2] = aux_ctrl_r[AOGC_DIAG_POS_BIT];
    diag_nxt[3] = aux_ctrl_r[AOGC_DIAG_NEG_BIT];
    diag_nxt[4] = hv_cfg_r[AOGC_ATTEN_BIT];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 16'h0000;
      diag_r <= 5'h00;
    end else begin
      rdata_r <= rdata_nxt;
      diag_r <= diag_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign cur_ready_o = cur_ready_r;
  assign aux_ready_o = aux_ready_r;
  assign shunt_pos_src_en_o = diag_r[0];
  assign shunt_neg_src_en_o = diag_r[1];
  assign temp_src_en_o = diag_r[2];
  assign switched_ground_src_en_o = diag_r[3];
  assign atten_src_en_o = diag_r[4];
endmodule

// File: design/aogc_pkg.sv
// constants and types for the adc offset and gain correction block
package aogc_pkg;
  localparam int AOGC_AW = 8;
  localparam int AOGC_DW = 16;
  localparam int AOGC_GAIN_FRAC = 14;
  localparam int AOGC_RES_W = 16;
  // register byte offsets
  localparam logic [7:0] AOGC_CUR_OFF_A = 8'h00;
  localparam logic [7:0] AOGC_CUR_GAIN_A = 8'h04;
  localparam logic [7:0] AOGC_AUX_OFF_A = 8'h08;
  localparam logic [7:0] AOGC_AUX_GAIN_A = 8'h0c;
  localparam logic [7:0] AOGC_CUR_CTRL_A = 8'h10;
  localparam logic [7:0] AOGC_AUX_CTRL_A = 8'h14;
  localparam logic [7:0] AOGC_HV_CFG_A = 8'h18;
  localparam logic [7:0] AOGC_MODE_A = 8'h1c;
  localparam logic [7:0] AOGC_CUR_RES_A = 8'h20;
  localparam logic [7:0] AOGC_AUX_RES_A = 8'h24;
  localparam logic [7:0] AOGC_STAT_A = 8'h28;
  // reset values
  localparam logic [15:0] AOGC_GAIN_NOM = 16'h5555;
  localparam logic [15:0] AOGC_OFF_RST = 16'h0000;
  localparam logic [15:0] AOGC_CTRL_RST = 16'h0000;
  // field positions
  localparam int AOGC_GCODE_LSB = 0;
  localparam int AOGC_DIAG_NEG_BIT = 13;
  localparam int AOGC_DIAG_POS_BIT = 14;
  localparam int AOGC_ATTEN_BIT = 7;
  localparam int AOGC_MODE_LSB = 0;
  localparam int AOGC_HALFREF_BIT = 2;
  localparam int AOGC_CUR_UNI_BIT = 3;
  localparam int AOGC_AUX_UNI_BIT = 4;
  localparam int AOGC_ST_CUR_OVF = 0;
  localparam int AOGC_ST_CUR_UNF = 1;
  localparam int AOGC_ST_AUX_OVF = 2;
  localparam int AOGC_ST_AUX_UNF = 3;
  localparam int AOGC_ST_CUR_NEW = 4;
  localparam int AOGC_ST_AUX_NEW = 5;
  localparam int AOGC_ST_CUR_LOST = 6;
  localparam int AOGC_ST_AUX_LOST = 7;
  localparam int AOGC_ST_IDLE = 8;
  localparam logic [8:0] AOGC_W1C_MASK = 9'h0cf;
  // amplifier gain codes
  localparam logic [3:0] AOGC_G2 = 4'h1;
  localparam logic [3:0] AOGC_G128 = 4'h7;
  localparam logic [3:0] AOGC_G256 = 4'h8;
  localparam logic [3:0] AOGC_G512 = 4'h9;
  // k as a left shift
  localparam logic [2:0] AOGC_K1 = 3'h0;
  localparam logic [2:0] AOGC_K2 = 3'h1;
  localparam logic [2:0] AOGC_K4 = 3'h2;
  localparam logic [2:0] AOGC_K8 = 3'h3;
  localparam logic [2:0] AOGC_K32 = 3'h5;
  localparam logic [1:0] AOGC_CAL_CUR_OFF = 2'h0;
  localparam logic [1:0] AOGC_CAL_CUR_GAIN = 2'h1;
  localparam logic [1:0] AOGC_CAL_AUX_OFF = 2'h2;
  localparam logic [1:0] AOGC_CAL_AUX_GAIN = 2'h3;

  typedef enum logic [1:0] {
    AOGC_NORMAL,
    AOGC_LOW_POWER,
    AOGC_LOW_POWER_PLUS,
    AOGC_MODE_RSVD
  } aogc_mode_t;
endpackage

// File: design/aogc_corr_if.sv
// carrier between the register side and one correction datapath
`timescale 1ns/100ps
interface aogc_corr_if #(
  parameter int FW = 24
);
  logic signed [FW-1:0] sample;
  logic valid;
  logic [15:0] offset;
  logic [15:0] gain;
  logic [2:0] kshift;
  logic unipolar;
  logic [15:0] result;
  logic done;
  logic ovf;
  logic unf;
  modport ctrl (output sample, valid, offset, gain, kshift, unipolar, input result, done, ovf, unf);
  modport corr (input sample, valid, offset, gain, kshift, unipolar, output result, done, ovf, unf);
endinterface

// File: design/aogc_corr.sv
// offset subtraction, gain scaling, rounding, clamping and formatting for one channel
`timescale 1ns/100ps
module aogc_corr #(
  parameter int FW = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // datapath carrier
  aogc_corr_if.corr cif
);
  import aogc_pkg::*;

  // headroom: k up to 64 on a full-scale offset needs eight extra bits
  localparam int AW = FW + 8;
  localparam int PW = AW + 17;
  localparam int SH = AOGC_GAIN_FRAC + FW - AOGC_RES_W;
  localparam logic signed [PW-1:0] RES_MAX = PW'(32767);
  localparam logic signed [PW-1:0] RES_MIN = -PW'(32768);

  if (FW < 16 || FW > 32) begin : fw_range_chk
    $error("aogc_corr: filter width must be 16 to 32");
  end

  logic signed [AW-1:0] off_al;
  logic signed [AW-1:0] diff;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] scaled;
  logic [15:0] result_r, result_nxt;
  logic done_r, done_nxt;
  logic ovf_r, ovf_nxt;
  logic unf_r, unf_nxt;

  always_comb begin
    off_al = AW'($signed(cif.offset)) <<< (FW - 16);
    off_al = off_al <<< cif.kshift;
    diff = AW'(cif.sample) - off_al;
    prod = PW'(diff) * $signed(PW'({1'b0, cif.gain}));
    scaled = (prod + (PW'(1) <<< (SH - 1))) >>> SH;
    result_nxt = result_r;
    ovf_nxt = 1'b0;
    unf_nxt = 1'b0;
    done_nxt = cif.valid;
    if (cif.valid) begin
      if (scaled > RES_MAX) begin
        ovf_nxt = 1'b1;
        result_nxt = 16'h7fff;
      end else if (scaled < RES_MIN) begin
        unf_nxt = 1'b1;
        result_nxt = 16'h8000;
      end else begin
        result_nxt = scaled[15:0];
      end
      if (cif.unipolar) begin
        result_nxt = result_nxt ^ 16'h8000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_r <= 16'h0000;
      done_r <= 1'b0;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      done_r <= done_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
    end
  end

  assign cif.result = result_r;
  assign cif.done = done_r;
  assign cif.ovf = ovf_r;
  assign cif.unf = unf_r;
endmodule

// File: sim/aogc_props.sv
// concurrent checks on the ports of the offset and gain correction block
`timescale 1ns/100ps
module aogc_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [aogc_pkg::AOGC_AW-1:0] addr_i,
  input wire logic [aogc_pkg::AOGC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [aogc_pkg::AOGC_DW-1:0] rdata_o,
  // sample strobes
  input wire logic cur_valid_i,
  input wire logic aux_valid_i,
  input wire logic cur_ready_o,
  input wire logic aux_ready_o,
  // diagnostic sources
  input wire logic shunt_pos_src_en_o,
  input wire logic shunt_neg_src_en_o,
  input wire logic temp_src_en_o,
  input wire logic switched_ground_src_en_o,
  input wire logic atten_src_en_o
);
  import aogc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////////
  cur_latency_a: assert property (cur_valid_i |-> ##2 cur_ready_o)
    else $error("current result strobe late");
  cur_cause_a: assert property (cur_ready_o |-> $past(cur_valid_i, 2))
    else $error("current result strobe without a sample");
  aux_latency_a: assert property (aux_valid_i |-> ##2 aux_ready_o)
    else $error("aux result strobe late");
  aux_cause_a: assert property (aux_ready_o |-> $past(aux_valid_i, 2))
    else $error("aux result strobe without a sample");
  // read data only in the cycle after a read, so a stuck value shows up here
  rdata_quiet_a: assert property (rdata_o != '0 |-> $past(rd_i))
    else $error("read data outside the read answer cycle");
  unmapped_read_a: assert property (rd_i && addr_i == 8'h30 |=> rdata_o == '0)
    else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////////////////////////
  shunt_pos_a: assert property (
    (wr_i && addr_i == AOGC_CUR_CTRL_A) ##1 !(wr_i && addr_i == AOGC_CUR_CTRL_A)
    |=> shunt_pos_src_en_o == $past(wdata_i[AOGC_DIAG_POS_BIT], 2)) else $error("shunt positive source wrong");
  shunt_neg_a: assert property (
    (wr_i && addr_i == AOGC_CUR_CTRL_A) ##1 !(wr_i && addr_i == AOGC_CUR_CTRL_A)
    |=> shunt_neg_src_en_o == $past(wdata_i[AOGC_DIAG_NEG_BIT], 2)) else $error("shunt negative source wrong");
  temp_src_a: assert property (
    (wr_i && addr_i == AOGC_AUX_CTRL_A) ##1 !(wr_i && addr_i == AOGC_AUX_CTRL_A)
    |=> temp_src_en_o == $past(wdata_i[AOGC_DIAG_POS_BIT], 2)) else $error("temperature source wrong");
  gnd_src_a: assert property (
    (wr_i && addr_i == AOGC_AUX_CTRL_A) ##1 !(wr_i && addr_i == AOGC_AUX_CTRL_A)
    |=> switched_ground_src_en_o == $past(wdata_i[AOGC_DIAG_NEG_BIT], 2)) else $error("ground switch source wrong");
  atten_src_a: assert property (
    (wr_i && addr_i == AOGC_HV_CFG_A) ##1 !(wr_i && addr_i == AOGC_HV_CFG_A)
    |=> atten_src_en_o == $past(wdata_i[AOGC_ATTEN_BIT], 2)) else $error("attenuator source wrong");
endmodule

bind adc_offset_gain_correction aogc_props aogc_props_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .cur_valid_i(cur_valid_i), .aux_valid_i(aux_valid_i), .cur_ready_o(cur_ready_o),
  .aux_ready_o(aux_ready_o), .shunt_pos_src_en_o(shunt_pos_src_en_o), .shunt_neg_src_en_o(shunt_neg_src_en_o),
  .temp_src_en_o(temp_src_en_o), .switched_ground_src_en_o(switched_ground_src_en_o), .atten_src_en_o(atten_src_en_o));

// File: sim/adc_offset_gain_correction_tb.sv
// self-checking bench for the offset and gain correction block
`timescale 1ns/100ps
module adc_offset_gain_correction_tb;
  import aogc_pkg::*;
  localparam int FW = 24;
  // not the nominal value, so a reset load of the wrong constant shows
  localparam logic [15:0] FG = 16'h4321;
  typedef struct {logic [2:0] mode; logic [3:0] gcode; int k;} aogc_row_t;
  logic clk_i, nrst_i, wr_i, rd_i, cur_valid_i, aux_valid_i, adc_idle_i, cal_wr_i, cur_ready_o, aux_ready_o;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, cal_coeff_i, rdata_o, rd_v;
  logic [1:0] cal_sel_i;
  logic signed [FW-1:0] cur_sample_i, aux_sample_i;
  wire [4:0] src;
  int num_errors = 0;
  int samples_checked = 0;
  // {half ref, mode}, gain code, expected k as a shift
  aogc_row_t rows [12] = '{'{3'h0, 4'h0, 0}, '{3'h0, 4'h1, 1}, '{3'h0, 4'h3, 0}, '{3'h0, 4'h7, 1},
    '{3'h0, 4'h8, 2}, '{3'h0, 4'h9, 3}, '{3'h1, 4'h7, 5}, '{3'h5, 4'h7, 6}, '{3'h2, 4'h9, 3},
    '{3'h6, 4'h9, 4}, '{3'h4, 4'h7, 1}, '{3'h3, 4'h8, 2}};

  adc_offset_gain_correction #(.FW(FW), .FACTORY_GAIN(FG)) adc_offset_gain_correction_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cur_sample_i(cur_sample_i), .cur_valid_i(cur_valid_i), .aux_sample_i(aux_sample_i),
    .aux_valid_i(aux_valid_i), .adc_idle_i(adc_idle_i), .cal_wr_i(cal_wr_i), .cal_sel_i(cal_sel_i),
    .cal_coeff_i(cal_coeff_i), .cur_ready_o(cur_ready_o), .aux_ready_o(aux_ready_o),
    .shunt_pos_src_en_o(src[4]), .shunt_neg_src_en_o(src[3]), .temp_src_en_o(src[2]),
    .switched_ground_src_en_o(src[1]), .atten_src_en_o(src[0]));

  ////////////////////////////////////////////////////////////////////////////////
  // 64-bit arithmetic so the product never wraps before the clamp
  function automatic logic [15:0] model(input longint s, input logic [15:0] off, input logic [15:0] g,
                                        input int k, input logic uni);
    longint p;
    p = ((s - (longint'($signed(off)) <<< (FW - 16 + k))) * longint'(g) + (longint'(1) <<< (FW - 3))) >>> (FW - 2);
    p = (p > 32767) ? 32767 : (p < -32768) ? -32768 : p;
    return p[15:0] ^ {uni, 15'h0};
  endfunction

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    rd_v = rdata_o;
  endtask

  task automatic cal(input logic [1:0] sel, input logic [15:0] v);
    @(posedge clk_i);
    cal_sel_i <= sel;
    cal_coeff_i <= v;
    cal_wr_i <= 1'b1;
    @(posedge clk_i);
    cal_wr_i <= 1'b0;
  endtask

  // one sample pulse, then a bounded wait for the result strobe
  task automatic sample(input logic aux, input logic signed [FW-1:0] s);
    int n;
    @(posedge clk_i);
    cur_sample_i <= s;
    aux_sample_i <= s;
    cur_valid_i <= !aux;
    aux_valid_i <= aux;
    @(posedge clk_i);
    cur_valid_i <= 1'b0;
    aux_valid_i <= 1'b0;
    n = 0;
    while ((aux ? aux_ready_o : cur_ready_o) !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 8) begin
      num_errors++;
      $display("mismatch result strobe expected 1 seen timeout");
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    nrst_i = 1'b0;
    {wr_i, rd_i, cur_valid_i, aux_valid_i, cal_wr_i} = '0;
    adc_idle_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    cal_sel_i = '0;
    cal_coeff_i = '0;
    cur_sample_i = '0;
    aux_sample_i = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    // unit gain makes k visible as a plain shift of the offset
    wr(AOGC_CUR_GAIN_A, 16'h4000);
    wr(AOGC_CUR_OFF_A, 16'h0010);
    foreach (rows[i]) begin
      wr(AOGC_MODE_A, {13'h0, rows[i].mode});
      wr(AOGC_CUR_CTRL_A, {12'h0, rows[i].gcode});
      sample(1'b0, 24'sh100000);
      rd(AOGC_CUR_RES_A);
      check("cur result", rd_v, model(64'sd1048576, 16'h0010, 16'h4000, rows[i].k, 1'b0));
    end
    $display("test k table done");
    // gain code 1 keeps software within its duty while the shunt sources are on
    wr(AOGC_CUR_CTRL_A, 16'h6001);
    wr(AOGC_AUX_CTRL_A, 16'h4000);
    wr(AOGC_HV_CFG_A, 16'h0080);
    repeat (2) @(negedge clk_i);
    check("sources on", {11'h0, src}, 16'h001d);
    wr(AOGC_CUR_CTRL_A, 16'h2001);
    wr(AOGC_AUX_CTRL_A, 16'h2000);
    wr(AOGC_HV_CFG_A, 16'h0000);
    repeat (2) @(negedge clk_i);
    check("sources swapped", {11'h0, src}, 16'h000a);
    $display("test sources done");
    // negative offset shows sign extension; aux unipolar format is exercised here too
    wr(AOGC_MODE_A, 16'h0010);
    wr(AOGC_AUX_OFF_A, 16'hff00);
    sample(1'b1, 24'sh300000);
    rd(AOGC_AUX_RES_A);
    check("aux result", rd_v, model(64'sd3145728, 16'hff00, 16'h5555, 0, 1'b1));
    $display("test aux done");
    wr(AOGC_MODE_A, 16'h0000);
    wr(AOGC_CUR_CTRL_A, 16'h0000);
    wr(AOGC_CUR_OFF_A, 16'h0000);
    wr(AOGC_CUR_GAIN_A, 16'h5555);
    sample(1'b0, 24'sh7fffff);
    rd(AOGC_CUR_RES_A);
    check("clamp high", rd_v, 16'h7fff);
    rd(AOGC_STAT_A);
    check("status ovf", rd_v & 16'h010f, 16'h0101);
    wr(AOGC_STAT_A, 16'h0001);
    wr(AOGC_MODE_A, 16'h0008);
    sample(1'b0, 24'sh800000);
    rd(AOGC_CUR_RES_A);
    check("clamp low unipolar", rd_v, 16'h0000);
    rd(AOGC_STAT_A);
    check("status unf", rd_v & 16'h010f, 16'h0102);
    $display("test clamp done");
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    check("sources reset", {11'h0, src}, 16'h0000);
    rd(AOGC_CUR_GAIN_A);
    check("cur gain reset", rd_v, FG);
    rd(AOGC_AUX_GAIN_A);
    check("aux gain reset", rd_v, AOGC_GAIN_NOM);
    rd(AOGC_CUR_OFF_A);
    check("offset reset", rd_v, 16'h0000);
    rd(8'h30);
    check("unmapped read", rd_v, 16'h0000);
    $display("test reset done");
    adc_idle_i <= 1'b0;
    wr(AOGC_CUR_OFF_A, 16'h1234);
    rd(AOGC_CUR_OFF_A);
    check("busy write", rd_v, 16'h0000);
    cal(2'h0, 16'h0abc);
    rd(AOGC_CUR_OFF_A);
    check("cal offset", rd_v, 16'h0abc);
    cal(2'h3, 16'h2000);
    rd(AOGC_AUX_GAIN_A);
    check("cal aux gain", rd_v, 16'h2000);
    cal(2'h1, 16'h1111);
    rd(AOGC_CUR_GAIN_A);
    check("cal cur gain", rd_v, 16'h1111);
    cal(2'h2, 16'h0222);
    rd(AOGC_AUX_OFF_A);
    check("cal aux offset", rd_v, 16'h0222);
    adc_idle_i <= 1'b1;
    $display("test idle done");
    test_done();
  end
endmodule
